// [design/wccw_pkg.sv]
// Package for the watchdog and clock configuration word decoder
`default_nettype none
package wccw_pkg;

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [3:0]  WCCW_OFF_RAW      = 4'h0;
  localparam logic [3:0]  WCCW_OFF_STATUS   = 4'h4;
  localparam logic [3:0]  WCCW_OFF_WDCTRL   = 4'h8;

  // ------------------------------------------------------------
  // Field positions in the configuration word
  // ------------------------------------------------------------
  localparam int          WCCW_RSV_HI_MSB   = 31;
  localparam int          WCCW_RSV_HI_LSB   = 24;
  localparam int          WCCW_FWDT_BIT     = 23;
  localparam int          WCCW_RSV_LO_MSB   = 22;
  localparam int          WCCW_RSV_LO_LSB   = 21;
  localparam int          WCCW_PS_MSB       = 20;
  localparam int          WCCW_PS_LSB       = 16;
  localparam int          WCCW_CSM_MSB      = 15;
  localparam int          WCCW_CSM_LSB      = 14;

  // ------------------------------------------------------------
  // Values
  // ------------------------------------------------------------
  localparam logic [4:0]  WCCW_PS_MAX       = 5'h14;
  localparam logic [31:0] WCCW_WORD_RST     = 32'hFFFFFFFF;
  localparam logic [31:0] WCCW_BAD_ADDR     = 32'h00000000;

  // Decoded settings
  typedef struct packed {
    logic       fixed_en;    // Watchdog forced on
    logic [4:0] ps_code;     // Saturated postscale code
    logic       sw_enable;   // Clock switching allowed
    logic       fscm_enable; // Fail-safe monitor on
    logic       rsv_ok;      // Reserved bits all one
  } wccw_cfg_t;

  // Loader states
  typedef enum logic [1:0] {
    WCCW_ST_RESET = 2'b00,
    WCCW_ST_RUN   = 2'b01
  } wccw_state_t;

endpackage
`default_nettype wire

// [design/wccw_decode.sv]
// Combinational decoder of the configuration word fields
`default_nettype none
module wccw_decode
  import wccw_pkg::*;
(
  // Raw word
  input  wire logic [31:0]       word_i,
  // Decoded settings
  output var wccw_pkg::wccw_cfg_t cfg_o
);

  // ------------------------------------------------------------
  // Field decode
  // ------------------------------------------------------------
  wire logic [4:0] ps_raw;
  wire logic [1:0] csm;
  assign ps_raw = word_i[WCCW_PS_MSB:WCCW_PS_LSB];
  assign csm    = word_i[WCCW_CSM_MSB:WCCW_CSM_LSB];

  // Saturate unlisted codes to maximum ratio
  assign cfg_o.ps_code     = (ps_raw > WCCW_PS_MAX) ? WCCW_PS_MAX : ps_raw;
  assign cfg_o.fixed_en    = word_i[WCCW_FWDT_BIT];
  // Upper bit one turns both off; 01 switching only; 00 both
  assign cfg_o.sw_enable   = ~csm[1];
  assign cfg_o.fscm_enable = ~csm[1] & ~csm[0];
  assign cfg_o.rsv_ok      = (&word_i[WCCW_RSV_HI_MSB:WCCW_RSV_HI_LSB])
                           & (&word_i[WCCW_RSV_LO_MSB:WCCW_RSV_LO_LSB]);

endmodule
`default_nettype wire

// [design/wccw_top.sv]
// Watchdog and clock configuration word loader with Wishbone slave
//
// Notes on behaviour
// - Fixed enable one: watchdog runs from reset, software cannot stop it.
// - Fixed enable zero: watchdog off after reset, software may enable it.
// - Postscale code n in bits 20..16 selects ratio one to two^n.
// - Postscale codes above 10100 act as 10100.
// - Clock field upper bit one disables switching and fail-safe monitor.
// - Clock field 01 allows switching, fail-safe monitor off.
// - Clock field 00 enables switching and fail-safe monitor.
`default_nettype none
module wccw_top
  import wccw_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // Configuration memory
  input  wire logic [31:0]       cfg_word_i,
  // Wishbone slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [3:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  // Decoded settings
  output logic                   watchdog_enable_o,
  output logic      [4:0]        watchdog_postscale_code_o,
  output logic                   clock_switch_enable_o,
  output logic                   fail_safe_monitor_enable_o,
  output logic                   cfg_loaded_o
);

  // ------------------------------------------------------------
  // Sampling state
  // ------------------------------------------------------------
  wccw_state_t          state_reg;
  wccw_state_t          state_next;
  logic [31:0]          word_reg;
  wccw_cfg_t            cfg_dec;
  wccw_cfg_t            cfg_reg;
  logic                 sw_wden_reg;
  logic                 sw_wden_next;
  logic                 ack_reg;
  logic [31:0]          dat_reg;

  // Decoder of the sampled word
  wccw_decode u_decode
  (
    .word_i (word_reg),
    .cfg_o  (cfg_dec)
  );

  // Leave sampling state one cycle after reset release
  assign state_next = WCCW_ST_RUN;

  // Capture word during reset, freeze afterwards
  // Every reset edge recaptures, so the last edge under reset wins;
  // a control write on the first edge after release is dropped.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_reg <= WCCW_ST_RESET;
      word_reg  <= cfg_word_i;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // Latch decoded settings on the first cycle after reset
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cfg_reg <= '0;
    end
    else
    begin
      case (state_reg)
        WCCW_ST_RESET: cfg_reg <= cfg_dec;
        WCCW_ST_RUN:   cfg_reg <= cfg_reg;
        default:       cfg_reg <= cfg_reg;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Wishbone decode
  // ------------------------------------------------------------

  // Offset match of the bus address
  function automatic logic addr_hit(input logic [3:0] adr, input logic [3:0] off);
    addr_hit = (adr == off);
  endfunction
  wire logic        req;
  wire logic        wr_ctrl;
  wire logic        hit_raw;
  wire logic        hit_stat;
  wire logic        hit_ctrl;
  wire logic [31:0] rd_mux;
  wire logic [31:0] stat_word;

  assign req      = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign hit_raw  = addr_hit(wb_adr_i, WCCW_OFF_RAW);
  assign hit_stat = addr_hit(wb_adr_i, WCCW_OFF_STATUS);
  assign hit_ctrl = addr_hit(wb_adr_i, WCCW_OFF_WDCTRL);
  assign wr_ctrl  = req & wb_we_i & hit_ctrl & wb_sel_i[0];

  // Software enable follows written bit 0; clear ignored under fixed enable
  assign sw_wden_next = wr_ctrl ? (wb_dat_i[0] | cfg_reg.fixed_en) : sw_wden_reg;

  // Status: bit 9 loaded, 8 reserved ok, 7 monitor, 6 switching, 5:1 postscale, 0 fixed
  assign stat_word = {16'h0000, 6'h00, state_reg == WCCW_ST_RUN, cfg_reg.rsv_ok,
                      cfg_reg.fscm_enable, cfg_reg.sw_enable, cfg_reg.ps_code,
                      cfg_reg.fixed_en};
  assign rd_mux = hit_raw  ? word_reg :
                  hit_stat ? stat_word :
                  hit_ctrl ? {31'h00000000, sw_wden_reg} : WCCW_BAD_ADDR;

  // Bus ack and read data, one cycle after request
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h00000000;
    end
    else
    begin
      ack_reg <= req;
      dat_reg <= req ? rd_mux : dat_reg;
    end
  end

  // Watchdog software enable
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sw_wden_reg <= 1'b0;
    end
    else if (state_reg == WCCW_ST_RESET)
    begin
      sw_wden_reg <= cfg_dec.fixed_en;
    end
    else
    begin
      sw_wden_reg <= sw_wden_next;
    end
  end

  // ------------------------------------------------------------
  // Registered outputs
  // ------------------------------------------------------------
  logic       wden_out_reg;
  logic [4:0] ps_out_reg;
  logic       csw_out_reg;
  logic       fscm_out_reg;
  logic       loaded_reg;

  // Settings and loaded flag to the pins
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wden_out_reg <= 1'b0;
      ps_out_reg   <= 5'h00;
      csw_out_reg  <= 1'b0;
      fscm_out_reg <= 1'b0;
      loaded_reg   <= 1'b0;
    end
    else
    begin
      wden_out_reg <= sw_wden_reg | cfg_reg.fixed_en;
      ps_out_reg   <= cfg_reg.ps_code;
      csw_out_reg  <= cfg_reg.sw_enable;
      fscm_out_reg <= cfg_reg.fscm_enable;
      loaded_reg   <= (state_reg == WCCW_ST_RUN);
    end
  end

  assign wb_ack_o                   = ack_reg;
  assign wb_dat_o                   = dat_reg;
  assign watchdog_enable_o          = wden_out_reg;
  assign watchdog_postscale_code_o  = ps_out_reg;
  assign clock_switch_enable_o      = csw_out_reg;
  assign fail_safe_monitor_enable_o = fscm_out_reg;
  assign cfg_loaded_o               = loaded_reg;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  a_fixed_forces_on: assert property (@(posedge clk_i) disable iff (rst_i)
    loaded_reg && cfg_reg.fixed_en |=> watchdog_enable_o)
    else $error("watchdog off while fixed enable set");

  a_clear_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_ctrl && !wb_dat_i[0] && cfg_reg.fixed_en |=> sw_wden_reg)
    else $error("software cleared fixed watchdog");

  a_off_after_reset: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(loaded_reg) == 1'b0 && state_reg == WCCW_ST_RESET && !cfg_dec.fixed_en |=> ##1 !watchdog_enable_o)
    else $error("watchdog on after reset without fixed enable");

  a_sw_can_enable: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_ctrl && wb_dat_i[0] && state_reg == WCCW_ST_RUN |=> ##1 watchdog_enable_o)
    else $error("software enable not honoured");

  a_ps_saturates: assert property (@(posedge clk_i) disable iff (rst_i)
    word_reg[WCCW_PS_MSB:WCCW_PS_LSB] > WCCW_PS_MAX |-> cfg_dec.ps_code == WCCW_PS_MAX)
    else $error("postscale not saturated");

  a_ps_passes: assert property (@(posedge clk_i) disable iff (rst_i)
    loaded_reg && word_reg[WCCW_PS_MSB:WCCW_PS_LSB] <= WCCW_PS_MAX
      |-> ##1 watchdog_postscale_code_o == $past(word_reg[WCCW_PS_MSB:WCCW_PS_LSB]))
    else $error("postscale code altered");

  a_csm_upper_off: assert property (@(posedge clk_i) disable iff (rst_i)
    loaded_reg && word_reg[WCCW_CSM_MSB] |-> !clock_switch_enable_o && !fail_safe_monitor_enable_o)
    else $error("clock switching active with field 1x");

  a_csm_01: assert property (@(posedge clk_i) disable iff (rst_i)
    loaded_reg && word_reg[WCCW_CSM_MSB:WCCW_CSM_LSB] == 2'b01
      |-> clock_switch_enable_o && !fail_safe_monitor_enable_o)
    else $error("field 01 decoded wrong");

  a_csm_00: assert property (@(posedge clk_i) disable iff (rst_i)
    loaded_reg && word_reg[WCCW_CSM_MSB:WCCW_CSM_LSB] == 2'b00
      |-> clock_switch_enable_o && fail_safe_monitor_enable_o)
    else $error("field 00 decoded wrong");

  a_word_held: assert property (@(posedge clk_i) disable iff (rst_i)
    state_reg == WCCW_ST_RUN |=> $stable(word_reg) && $stable(cfg_reg))
    else $error("configuration changed outside reset");

  a_clear_allowed: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_ctrl && !wb_dat_i[0] && !cfg_reg.fixed_en && state_reg == WCCW_ST_RUN |=> !sw_wden_reg)
    else $error("software clear of watchdog refused");

  a_sel_gates_write: assert property (@(posedge clk_i) disable iff (rst_i)
    req && wb_we_i && hit_ctrl && !wb_sel_i[0] && state_reg == WCCW_ST_RUN |=> $stable(sw_wden_reg))
    else $error("control write taken without byte enable");

  a_monitor_needs_switch: assert property (@(posedge clk_i) disable iff (rst_i)
    fail_safe_monitor_enable_o |-> clock_switch_enable_o)
    else $error("monitor on while switching off");

  a_rsv_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    state_reg == WCCW_ST_RUN |-> cfg_reg.rsv_ok == ((&word_reg[WCCW_RSV_HI_MSB:WCCW_RSV_HI_LSB])
                                                  && (&word_reg[WCCW_RSV_LO_MSB:WCCW_RSV_LO_LSB])))
    else $error("reserved bit report wrong");

  // Loader timing after reset release
  a_loaded_timing: assert property (@(posedge clk_i) disable iff (rst_i)
    state_reg == WCCW_ST_RESET |=> !cfg_loaded_o ##1 cfg_loaded_o)
    else $error("loaded flag timing wrong");

  a_outputs_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    state_reg == WCCW_ST_RESET |=> !watchdog_enable_o && !clock_switch_enable_o && !fail_safe_monitor_enable_o)
    else $error("settings shown before load");

  // Bus handshake and read data
  a_ack_follows: assert property (@(posedge clk_i) disable iff (rst_i)
    req |=> wb_ack_o)
    else $error("request not acknowledged");

  a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge longer than one cycle");

  a_no_ack_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("acknowledge without request");

  a_unmapped_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    req && !hit_raw && !hit_stat && !hit_ctrl |=> wb_dat_o == WCCW_BAD_ADDR)
    else $error("unmapped read not zero");

  a_raw_readback: assert property (@(posedge clk_i) disable iff (rst_i)
    req && hit_raw |=> wb_dat_o == word_reg)
    else $error("raw word read wrong");

  a_ctrl_readback: assert property (@(posedge clk_i) disable iff (rst_i)
    req && hit_ctrl && !wb_we_i |=> wb_dat_o == {31'h00000000, $past(sw_wden_reg)})
    else $error("control read wrong");

  c_fixed_on:   cover property (@(posedge clk_i) disable iff (rst_i) loaded_reg && cfg_reg.fixed_en);
  c_sw_enable:  cover property (@(posedge clk_i) disable iff (rst_i) wr_ctrl && wb_dat_i[0] && !cfg_reg.fixed_en);
  c_saturate:   cover property (@(posedge clk_i) disable iff (rst_i)
                  loaded_reg && word_reg[WCCW_PS_MSB:WCCW_PS_LSB] > WCCW_PS_MAX);
  c_fscm_on:    cover property (@(posedge clk_i) disable iff (rst_i) fail_safe_monitor_enable_o);
  c_rsv_bad:    cover property (@(posedge clk_i) disable iff (rst_i) loaded_reg && !cfg_reg.rsv_ok);

endmodule
`default_nettype wire

// [testbench/wccw_prog_model.sv]
// Model of the programming tool that writes the configuration word
`default_nettype none
module wccw_prog_model
(
  // Field choices
  input  wire logic        fixed_i,
  input  wire logic [4:0]  ps_i,
  input  wire logic [1:0]  csm_i,
  input  wire logic [31:0] noise_i,
  input  wire logic        bad_rsv_i,
  // Word to configuration memory
  output logic      [31:0] word_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // Builds the word; reserved ones broken only when asked
  always_comb
  begin
    word_o = noise_i;
    word_o[31:24] = bad_rsv_i ? 8'h7F : 8'hFF;
    word_o[22:21] = bad_rsv_i ? 2'h2 : 2'h3;
    word_o[23] = fixed_i;
    word_o[20:16] = ps_i;
    word_o[15:14] = csm_i;
    if (word_o[9:8] == 2'h0)
      word_o[9:8] = 2'h1;
  end
endmodule
`default_nettype wire

// [testbench/wccw_top_tb_top.sv]
// Self-checking bench for the configuration word loader
`default_nettype none
module wccw_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic        clk_i, rst_i, cyc, stb, we, fixed, bad, ack, wd_en, sw_en, fs_en, loaded;
  logic [3:0]  adr, sel;
  logic [4:0]  ps, ps_o;
  logic [1:0]  csm;
  logic [31:0] wdat, word, noise, rdat, dat_o, raw;
  int          mismatches, total_checks, seed, n;

  // Far side and design
  wccw_prog_model prog (.fixed_i(fixed), .ps_i(ps), .csm_i(csm), .noise_i(noise),
                        .bad_rsv_i(bad), .word_o(word));
  wccw_top uut (.clk_i(clk_i), .rst_i(rst_i), .cfg_word_i(word), .wb_cyc_i(cyc), .wb_stb_i(stb),
                .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o),
                .wb_ack_o(ack), .watchdog_enable_o(wd_en), .watchdog_postscale_code_o(ps_o),
                .clock_switch_enable_o(sw_en), .fail_safe_monitor_enable_o(fs_en),
                .cfg_loaded_o(loaded));

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  // Verdict and end of run
  task automatic stop_test();
    if (mismatches == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Compare one value
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Classic single Wishbone cycle, read data kept in rdat
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
    int k;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    for (k = 0; k < 20; k++)
    begin
      @(posedge clk_i);
      if (ack === 1'b1)
        break;
    end
    if (k == 20)
    begin
      mismatches++;
      stop_test();
    end
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask

  // One load of a word, then bus traffic against the model
  task automatic run(input logic f, input logic [4:0] p, input logic [1:0] c, input logic b);
    logic [4:0] eps;
    fixed <= f;
    ps <= p;
    csm <= c;
    bad <= b;
    noise <= $random(seed);
    rst_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    check(32'({wd_en, ps_o, sw_en, fs_en, loaded}), 32'h0);
    raw = word;
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    eps = (p > 5'h14) ? 5'h14 : p;
    check(32'(wd_en), 32'(f));
    check(32'(ps_o), 32'(eps));
    check(32'(sw_en), 32'(!c[1]));
    check(32'(fs_en), 32'(c == 2'h0));
    check(32'(loaded), 32'h1);
    fixed <= ~f;
    ps <= ~p;
    csm <= ~c;
    bad <= ~b;
    wb(1'b0, 4'h0, 32'h0, 4'hF);
    check(rdat, raw);
    wb(1'b0, 4'h4, 32'h0, 4'hF);
    check(rdat, {22'h0, 1'b1, !b, c == 2'h0, !c[1], eps, f});
    wb(1'b1, 4'h8, 32'h1, 4'hE);
    repeat (2) @(posedge clk_i);
    check(32'(wd_en), 32'(f));
    wb(1'b1, 4'h8, 32'h1, 4'hF);
    repeat (2) @(posedge clk_i);
    check(32'(wd_en), 32'h1);
    wb(1'b0, 4'h8, 32'h0, 4'hF);
    check(rdat, 32'h1);
    wb(1'b1, 4'h8, 32'h0, 4'hF);
    repeat (2) @(posedge clk_i);
    check(32'(wd_en), 32'(f));
    wb(1'b1, 4'hC, 32'hFFFFFFFF, 4'hF);
    wb(1'b0, 4'hC, 32'h0, 4'hF);
    check(rdat, 32'h0);
    check(32'({ps_o, sw_en, fs_en}), 32'({eps, !c[1], c == 2'h0}));
  endtask

  // ------------------------------------------------------------
  // Clock and main sequence
  // ------------------------------------------------------------
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // Every postscale code and every clock field value
  initial
  begin
    rst_i = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 4'h0;
    sel = 4'h0;
    wdat = 32'h0;
    fixed = 1'b0;
    ps = 5'h0;
    csm = 2'h0;
    bad = 1'b0;
    noise = 32'h0;
    seed = 1;
    mismatches = 0;
    total_checks = 0;
    for (n = 0; n < 40; n++)
      run(n[0], (n < 32) ? n[4:0] : 5'($random(seed)), n[2:1], n % 7 == 3);
    stop_test();
  end
endmodule
`default_nettype wire
